// *** core/port_cfg_defs.vh ***
// constants for the port configuration, keypad wake and clock output block
`ifndef PORT_CFG_DEFS_VH
`define PORT_CFG_DEFS_VH
`define MODE_QUASI 2'h0
`define MODE_PUSH 2'h1
`define MODE_INPUT 2'h2
`define MODE_OPEN 2'h3
`define OSC_LOW_XTAL 3'h0
`define OSC_MED_XTAL 3'h1
`define OSC_HIGH_XTAL 3'h2
`define OSC_RC 3'h3
`define OSC_EXT 3'h4
`define STRONG_PULSE_CLKS 2'h2
`define CLKOUT_DIV 3'h6
`define CLKOUT_HALF 3'h3
`define PORT2_MODE_REG_ONE_BIT_CLOCK_OUT_ENABLE 7
`define PORT2_MODE_REG_ONE_BIT_ENT1 6
`define PORT2_MODE_REG_ONE_BIT_ENT0 5
`define PORT2_MODE_REG_ONE_BIT_SCH2 4
`define PORT2_MODE_REG_ONE_BIT_SCH1 3
`define PORT2_MODE_REG_ONE_BIT_SCH0 2
`define PORT2_MODE_REG_ONE_RESET 8'h00
`define PORT_BIT_OD_A 2
`define PORT_BIT_OD_B 3
`define PORT_BIT_RST 5
`endif

// *** core/pin_driver.v ***
// one port pin output driver: mode decode and strong pull-up pulse
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg_defs.vh"
module pin_driver (
	input wire ref_clk, // system clock
	input wire sys_rst, // synchronous reset, active high
	input wire cpu_en, // one cycle per cpu clock
	input wire [1:0] mode, // output mode code
	input wire latch, // port latch value
	input wire disable_pin, // pin removed from service
	output reg pull_down, // strong pull-down on
	output reg strong_up, // strong pull-up on
	output reg weak_up // weak pull-ups on
);
	reg latch_q;
	reg [1:0] pulse_q;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			latch_q <= 1'b1;
			pulse_q <= 2'h0;
		end else begin
			latch_q <= latch;
			if (mode == `MODE_QUASI && latch && !latch_q)
				pulse_q <= `STRONG_PULSE_CLKS; // RULE_21
			else if (cpu_en && pulse_q != 2'h0)
				pulse_q <= pulse_q - 2'h1;
		end
	end
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pull_down <= 1'b0;
			strong_up <= 1'b0;
			weak_up <= 1'b0;
		end else if (disable_pin || mode == `MODE_INPUT) begin
			pull_down <= 1'b0;
			strong_up <= 1'b0;
			weak_up <= 1'b0;
		end else begin
			pull_down <= !latch; // RULE_01
			strong_up <= (mode == `MODE_PUSH && latch) || (mode == `MODE_QUASI && latch && (!latch_q || pulse_q != 2'h0)); // RULE_02
			weak_up <= (mode == `MODE_QUASI) && latch; // RULE_01
		end
	end
endmodule
`default_nettype wire

// *** core/port_config_keypad_wake_clkout.v ***
// port configuration, keypad wake-up and clock output top level
// Overview of operation
// RULE_01 - open drain: no pull-ups, pull-down only when latch is 0
// RULE_02 - push-pull: shared pull-down, continuous strong pull-up when latch is 1
// RULE_03 - port 1 bits 2 and 3 fixed open drain whatever the mode bits
// RULE_04 - software writes 1 to those latches before reading them as inputs
// RULE_05 - port 1 bit 5 is Schmitt input only with internal reset
// RULE_06 - crystal options disable port 2 bits 0 and 1 entirely
// RULE_07 - reset pin level follows reset-high select; high pins are quasi-bidirectional
// RULE_08 - spare port 2 mode bits: Schmitt enables, timer toggles, clock out
// RULE_09 - one bit per port selects TTL or Schmitt input
// RULE_10 - port 1 bits 2, 3, 5 always Schmitt
// RULE_11 - one keypad enable bit per port 0 pin
// RULE_12 - enabled low pin sets keypad flag; interrupt only if enabled
// RULE_13 - hardware never clears keypad flag; software clears it
// RULE_14 - enabled keypad interrupt wakes from Idle and Power Down
// RULE_15 - clock out only with RC or external clock, gated by enable
// RULE_16 - clock out keeps toggling during Idle while enabled
// RULE_17 - clock out frequency is cpu clock over six
// RULE_18 - external clock: oscillator out pin is a port pin unless clock out
// RULE_19 - RC oscillator clock divisible by the cpu clock divider
// RULE_20 - two mode bits per pin: quasi, push-pull, input only, open drain
// RULE_21 - quasi mode latch rising 0 to 1 gives two-clock strong pull-up
// RULE_22 - divider N gives divide by 2*(N+1); zero means undivided; the code divides N of 128 to 255 by 2*(N-127)
// RULE_23 - port 0 keypad inputs synchronised; async path wakes with stopped oscillator; the code registers the raw path into keypad_wake on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg_defs.vh"
module port_config_keypad_wake_clkout (
	input wire ref_clk, // oscillator clock
	input wire sys_rst, // synchronous reset, active high
	input wire port_reset_high_select, // reset level of port pins
	input wire internal_reset_sel, // device uses internal reset
	input wire [2:0] osc_select, // oscillator option
	input wire [7:0] port_mode_reg_a0, // port 0 mode bits a
	input wire [7:0] port_mode_reg_b0, // port 0 mode bits b
	input wire [7:0] port_mode_reg_a1, // port 1 mode bits a
	input wire [7:0] port_mode_reg_b1, // port 1 mode bits b
	input wire [7:0] port2_mode_reg_one, // port 2 mode bits a plus spare enables
	input wire [7:0] port_mode_reg_b2, // port 2 mode bits b
	input wire [7:0] latch0, // port 0 latches
	input wire [7:0] latch1, // port 1 latches
	input wire [7:0] latch2, // port 2 latches
	input wire [7:0] pin0_in, // port 0 pin levels
	input wire [7:0] pin1_in, // port 1 pin levels
	input wire [7:0] pin2_in, // port 2 pin levels
	input wire [7:0] keypad_pin_enable_reg, // keypad pin enables
	input wire keypad_active, // keypad function active
	input wire keypad_irq_enable, // keypad interrupt enable
	input wire keypad_flag_clear, // software clear of keypad flag
	input wire [7:0] cpu_clock_divider, // cpu clock divider value
	input wire idle_mode, // cpu in idle
	input wire power_down, // cpu in power down
	output reg [23:0] pull_down, // per-pin pull-down enable
	output reg [23:0] strong_up, // per-pin strong pull-up enable
	output reg [23:0] weak_up, // per-pin weak pull-up enable
	output reg [23:0] input_valid, // per-pin input buffer enabled
	output reg [23:0] schmitt_sel, // per-pin Schmitt buffer select
	output reg [7:0] port0_sync, // synchronised port 0
	output reg keypad_event_flag, // sticky keypad flag
	output reg keypad_irq, // keypad interrupt request
	output reg keypad_wake, // wake request from idle or power down
	output reg cpu_en, // cpu clock enable pulse
	output reg osc_out_clock_pin, // clock output level
	output reg clkout_active, // oscillator out pin carries clock
	output reg timer0_toggle_en, // timer 0 toggle output enable
	output reg timer1_toggle_en // timer 1 toggle output enable
);
	function [1:0] pin_mode;
		input [7:0] ma;
		input [7:0] mb;
		input [2:0] idx;
		pin_mode = {ma[idx], mb[idx]}; // RULE_20
	endfunction
	reg [7:0] div_cnt_q;
	reg [2:0] clk_cnt_q;
	reg [7:0] p0_meta_q;
	reg rst_done_q;
	wire xtal_opt = (osc_select == `OSC_LOW_XTAL) || (osc_select == `OSC_MED_XTAL) ||
		(osc_select == `OSC_HIGH_XTAL);
	wire clkout_ok = ((osc_select == `OSC_RC) || (osc_select == `OSC_EXT)) &&
		port2_mode_reg_one[`PORT2_MODE_REG_ONE_BIT_CLOCK_OUT_ENABLE]; // RULE_15
	wire [23:0] pd_w;
	wire [23:0] su_w;
	wire [23:0] wu_w;
	reg [47:0] mode_w;
	reg [23:0] latch_w;
	reg [23:0] dis_w;
	integer i;
	always @* begin
		latch_w = {latch2, latch1, latch0};
		dis_w = 24'h00_0000;
		mode_w = 48'h0000_0000_0000;
		for (i = 0; i < 8; i = i + 1) begin
			mode_w[2*i +: 2] = pin_mode(port_mode_reg_a0, port_mode_reg_b0, i[2:0]);
			mode_w[16 + 2*i +: 2] = pin_mode(port_mode_reg_a1, port_mode_reg_b1, i[2:0]);
			mode_w[32 + 2*i +: 2] = pin_mode({6'h00, port2_mode_reg_one[1:0]}, port_mode_reg_b2, i[2:0]);
		end
		mode_w[16 + 2*`PORT_BIT_OD_A +: 2] = `MODE_OPEN; // RULE_03
		mode_w[16 + 2*`PORT_BIT_OD_B +: 2] = `MODE_OPEN; // RULE_03
		mode_w[16 + 2*`PORT_BIT_RST +: 2] = `MODE_INPUT; // RULE_05
		if (!rst_done_q)
			mode_w = 48'h0000_0000_0000; // RULE_07
		if (!rst_done_q)
			latch_w = {24{port_reset_high_select}}; // RULE_07
		dis_w[16] = xtal_opt; // RULE_06
		dis_w[17] = xtal_opt; // RULE_06
		dis_w[16] = dis_w[16] | clkout_ok; // RULE_18
	end
	genvar g;
	generate
		for (g = 0; g < 24; g = g + 1) begin : pins
			pin_driver u_drv (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.cpu_en(cpu_en),
				.mode(mode_w[2*g +: 2]),
				.latch(latch_w[g]),
				.disable_pin(dis_w[g]),
				.pull_down(pd_w[g]),
				.strong_up(su_w[g]),
				.weak_up(wu_w[g])
			);
		end
	endgenerate
	// the drivers already register their outputs; one more stage keeps every top output a flop
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pull_down <= 24'h00_0000;
			strong_up <= 24'h00_0000;
			weak_up <= 24'h00_0000;
			input_valid <= 24'h00_0000;
			schmitt_sel <= 24'h00_0000;
			rst_done_q <= 1'b0;
		end else begin
			rst_done_q <= 1'b1;
			pull_down <= pd_w;
			strong_up <= su_w;
			weak_up <= wu_w;
			input_valid <= ~dis_w; // RULE_06
			input_valid[8 + `PORT_BIT_RST] <= internal_reset_sel; // RULE_05
			schmitt_sel <= {{8{port2_mode_reg_one[`PORT2_MODE_REG_ONE_BIT_SCH2]}}, {8{port2_mode_reg_one[`PORT2_MODE_REG_ONE_BIT_SCH1]}},
				{8{port2_mode_reg_one[`PORT2_MODE_REG_ONE_BIT_SCH0]}}}; // RULE_09
			schmitt_sel[8 + `PORT_BIT_OD_A] <= 1'b1; // RULE_10
			schmitt_sel[8 + `PORT_BIT_OD_B] <= 1'b1; // RULE_10
			schmitt_sel[8 + `PORT_BIT_RST] <= 1'b1; // RULE_10
		end
	end
	// cpu clock enable from divider; nonzero N divides by 2*(N[6:0]+1) oscillator clocks, zero undivided
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			div_cnt_q <= 8'h00;
			cpu_en <= 1'b0;
		end else if (cpu_clock_divider == 8'h00) begin
			div_cnt_q <= 8'h00;
			cpu_en <= 1'b1; // RULE_22
		end else if (div_cnt_q >= {cpu_clock_divider[6:0], 1'b1}) begin
			div_cnt_q <= 8'h00;
			cpu_en <= 1'b1; // RULE_19
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
			cpu_en <= 1'b0;
		end
	end
	// clock output: toggle every third cpu clock; runs in idle, not in power down
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_cnt_q <= 3'h0;
			osc_out_clock_pin <= 1'b0;
			clkout_active <= 1'b0;
			timer0_toggle_en <= 1'b0;
			timer1_toggle_en <= 1'b0;
		end else begin
			clkout_active <= clkout_ok; // RULE_18
			timer0_toggle_en <= port2_mode_reg_one[`PORT2_MODE_REG_ONE_BIT_ENT0]; // RULE_08
			timer1_toggle_en <= port2_mode_reg_one[`PORT2_MODE_REG_ONE_BIT_ENT1]; // RULE_08
			if (!clkout_ok || power_down) begin
				clk_cnt_q <= 3'h0;
				osc_out_clock_pin <= 1'b0;
			end else if (cpu_en) begin
				if (clk_cnt_q == `CLKOUT_HALF - 3'h1) begin
					clk_cnt_q <= 3'h0;
					osc_out_clock_pin <= ~osc_out_clock_pin; // RULE_17 RULE_16
				end else
					clk_cnt_q <= clk_cnt_q + 3'h1;
			end
		end
	end
	// keypad detect: synchronised path for the flag, raw path for power-down wake
	wire kp_hit = keypad_active && |(keypad_pin_enable_reg & ~port0_sync);
	wire kp_raw = keypad_active && |(keypad_pin_enable_reg & ~pin0_in);
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			p0_meta_q <= 8'hFF;
			port0_sync <= 8'hFF;
			keypad_event_flag <= 1'b0;
			keypad_irq <= 1'b0;
			keypad_wake <= 1'b0;
		end else begin
			p0_meta_q <= pin0_in; // RULE_23
			port0_sync <= p0_meta_q; // RULE_23
			if (kp_hit)
				keypad_event_flag <= 1'b1; // RULE_12 RULE_11
			else if (keypad_flag_clear)
				keypad_event_flag <= 1'b0; // RULE_13
			keypad_irq <= (keypad_event_flag || kp_hit) && keypad_irq_enable; // RULE_12
			keypad_wake <= keypad_irq_enable && (idle_mode || power_down) &&
				(keypad_event_flag || kp_hit || (power_down && kp_raw)); // RULE_14 RULE_23
		end
	end
endmodule
`default_nettype wire

// *** verif/port_cfg_properties.sv ***
// assertion checker for the port configuration, keypad and clock output block
`timescale 1ns/1ps
`default_nettype none
`include "port_cfg_defs.vh"
module port_cfg_properties (
	input wire logic ref_clk, // clock
	input wire logic sys_rst, // reset
	input wire logic [7:0] latch1, // latches
	input wire logic [2:0] osc_select, // osc option
	input wire logic [7:0] keypad_pin_enable_reg, // key enables
	input wire logic keypad_active, // key on
	input wire logic keypad_irq_enable, // irq enable
	input wire logic keypad_flag_clear, // clear
	input wire logic [7:0] cpu_clock_divider, // divider
	input wire logic [23:0] pull_down, // downs
	input wire logic [23:0] strong_up, // strong
	input wire logic [23:0] weak_up, // weak
	input wire logic [23:0] input_valid, // inputs
	input wire logic [23:0] schmitt_sel, // schmitt
	input wire logic [7:0] port0_sync, // synced
	input wire logic keypad_event_flag, // flag
	input wire logic keypad_irq, // irq
	input wire logic osc_out_clock_pin // clock out
);
	logic [2:0] settle_q;
	// outputs lag the forced reset values, so checks wait until that pipeline has flushed
	always @(posedge ref_clk) begin
		if (sys_rst) settle_q <= 3'h0;
		else if (settle_q != 3'h7) settle_q <= settle_q + 3'h1;
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst || settle_q != 3'h7);
	a_od_low_drive: assert property (!$past(latch1[2], 2) |-> pull_down[10] && !strong_up[10] && !weak_up[10])
		else $error("open drain pin not pulled low");
	a_od_high_float: assert property ($past(latch1[3], 2) |-> !pull_down[11] && !strong_up[11] && !weak_up[11])
		else $error("open drain pin driven");
	a_fixed_schmitt: assert property (schmitt_sel[10] && schmitt_sel[11] && schmitt_sel[13])
		else $error("fixed pin lost schmitt");
	a_xtal_pins_off: assert property ($past(osc_select) <= `OSC_HIGH_XTAL && $past(osc_select, 2) <= `OSC_HIGH_XTAL
		|-> !(input_valid[17:16] | pull_down[17:16] | strong_up[17:16] | weak_up[17:16]))
		else $error("crystal pins active");
	a_flag_sticky: assert property (keypad_event_flag && !keypad_flag_clear |=> keypad_event_flag)
		else $error("flag cleared by hardware");
	a_flag_set: assert property (keypad_active && |(keypad_pin_enable_reg & ~port0_sync) |=> keypad_event_flag)
		else $error("flag not set");
	// the request follows a fresh hit in the same cycle as the flag, not one cycle later
	a_irq_gate: assert property (keypad_irq == $past((keypad_event_flag || (keypad_active &&
		|(keypad_pin_enable_reg & ~port0_sync))) && keypad_irq_enable))
		else $error("irq not gated by enable");
	a_clkout_div6: assert property ($rose(osc_out_clock_pin) && cpu_clock_divider == 8'h00 &&
		$past(cpu_clock_divider) == 8'h00
		|=> osc_out_clock_pin [*2] ##1 !osc_out_clock_pin)
		else $error("clock out not cpu over six");
	c_flag: cover property ($rose(keypad_event_flag));
	c_clkout: cover property ($rose(osc_out_clock_pin));
	c_od_low: cover property (pull_down[10]);
endmodule
bind port_config_keypad_wake_clkout port_cfg_properties i_port_cfg_properties (.ref_clk, .sys_rst, .latch1,
	.osc_select, .keypad_pin_enable_reg, .keypad_active, .keypad_irq_enable, .keypad_flag_clear, .cpu_clock_divider,
	.pull_down, .strong_up, .weak_up, .input_valid, .schmitt_sel, .port0_sync, .keypad_event_flag, .keypad_irq,
	.osc_out_clock_pin);
`default_nettype wire

// *** verif/pin_load_model.sv ***
// keys and pull-up loads on the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
	input wire logic [23:0] key_down, // key closures
	input wire logic [23:0] drive_low, // pull-downs
	output logic [23:0] pin_level // pin levels
);
	// each pin has an external pull-up, so a released pin reads high
	assign pin_level = ~(key_down | drive_low);
endmodule
`default_nettype wire

// *** verif/port_config_keypad_wake_clkout_tb.sv ***
// self-checking bench for the port configuration, keypad and clock output block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module port_config_keypad_wake_clkout_tb;
	logic ref_clk = 1'b0, sys_rst = 1'b1, port_reset_high_select = 1'b1, internal_reset_sel = 1'b0, idle_mode = 1'b0;
	logic keypad_active = 1'b0, keypad_irq_enable = 1'b0, keypad_flag_clear = 1'b0, power_down = 1'b0;
	logic [2:0] osc_select = 3'h3;
	logic [7:0] port_mode_reg_a0 = 8'h00, port_mode_reg_b0 = 8'h00, port_mode_reg_a1 = 8'h00, port_mode_reg_b1 = 8'h00;
	logic [7:0] port2_mode_reg_one = 8'h00, port_mode_reg_b2 = 8'h00, latch0 = 8'h00, latch1 = 8'h00, latch2 = 8'h00;
	logic [7:0] keypad_pin_enable_reg = 8'h00, cpu_clock_divider = 8'h00, port0_sync;
	logic [23:0] key = 24'h00_0000, pins, pull_down, strong_up, weak_up, input_valid, schmitt_sel;
	logic keypad_event_flag, keypad_irq, keypad_wake, osc_out_clock_pin, clkout_active, timer0_toggle_en, timer1_toggle_en;
	int fails = 0, checked = 0, cyc = 0, n;
	port_config_keypad_wake_clkout i_port_config_keypad_wake_clkout (.ref_clk, .sys_rst, .port_reset_high_select,
		.internal_reset_sel, .osc_select, .port_mode_reg_a0, .port_mode_reg_b0, .port_mode_reg_a1, .port_mode_reg_b1,
		.port2_mode_reg_one, .port_mode_reg_b2, .latch0, .latch1, .latch2, .pin0_in(pins[7:0]), .pin1_in(pins[15:8]),
		.pin2_in(pins[23:16]), .keypad_pin_enable_reg, .keypad_active, .keypad_irq_enable, .keypad_flag_clear,
		.cpu_clock_divider, .idle_mode, .power_down, .pull_down, .strong_up, .weak_up, .input_valid, .schmitt_sel,
		.port0_sync, .keypad_event_flag, .keypad_irq, .keypad_wake, .cpu_en(), .osc_out_clock_pin, .clkout_active,
		.timer0_toggle_en, .timer1_toggle_en);
	pin_load_model i_pin_load_model (.key_down(key), .drive_low(pull_down), .pin_level(pins));
	initial forever #50 ref_clk = ~ref_clk;
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic count_toggles(input int len);
		logic last;
		last = osc_out_clock_pin;
		n = 0;
		repeat (len) begin
			step(1);
			if (osc_out_clock_pin !== last) n++;
			last = osc_out_clock_pin;
		end
	endtask
	initial begin
		step(6);
		sys_rst = 1'b0;
		n = 0;
		repeat (5) begin
			step(1);
			n += weak_up[0];
		end
		`CHK("reset_high", 1'b1, n > 0);
		`CHK("quasi_low", 1'b1, pull_down[0]);
		$display("done reset_level");
		port_mode_reg_b1 = 8'h0c;
		latch1 = 8'h08;
		port_mode_reg_a0 = 8'h02;
		port_mode_reg_b0 = 8'h03;
		latch0 = 8'h03;
		step(3);
		`CHK("od_low", 3'b100, {pull_down[10], strong_up[10], weak_up[10]});
		`CHK("od_high", 3'b000, {pull_down[11], strong_up[11], weak_up[11]});
		`CHK("od_p0", 3'b000, {pull_down[1], strong_up[1], weak_up[1]});
		`CHK("pp_high", 2'b10, {strong_up[0], pull_down[0]});
		latch0 = 8'h00;
		latch1 = 8'h0c;
		step(3);
		`CHK("pp_low", 2'b01, {strong_up[0], pull_down[0]});
		`CHK("od_read", 1'b1, pins[10] & ~pull_down[10]);
		port_mode_reg_b0 = 8'h00;
		step(3);
		latch0 = 8'hff;
		n = 0;
		repeat (8) begin
			step(1);
			n += strong_up[0];
		end
		`CHK("quasi_pulse", 1'b1, n >= 2 && n <= 3);
		$display("done drivers");
		for (int p = 0; p < 3; p++) begin
			port2_mode_reg_one = 8'h60 | (8'h04 << p);
			internal_reset_sel = p[0];
			step(2);
			`CHK("schmitt", (24'h00_00ff << (8 * p)) | 24'h00_2c00, schmitt_sel);
			`CHK("p1b5_in", internal_reset_sel, input_valid[13]);
			`CHK("timers", 2'b11, {timer0_toggle_en, timer1_toggle_en});
		end
		for (int o = 0; o < 4; o++) begin
			osc_select = o[2:0];
			step(3);
			`CHK("osc_pins", o == 3 ? 4'hf : 4'h0, {input_valid[17:16], pull_down[17:16]});
		end
		$display("done config");
		keypad_pin_enable_reg = 8'h08;
		keypad_active = 1'b1;
		key = 24'h00_0020;
		step(6);
		`CHK("kp_masked", 1'b0, keypad_event_flag);
		key = 24'h00_0008;
		step(4);
		`CHK("kp_set", 2'b10, {keypad_event_flag, keypad_irq});
		key = 24'h00_0000;
		step(6);
		`CHK("kp_sticky", 1'b1, keypad_event_flag);
		keypad_irq_enable = 1'b1;
		step(2);
		`CHK("kp_irq", 1'b1, keypad_irq);
		keypad_flag_clear = 1'b1;
		step(1);
		keypad_flag_clear = 1'b0;
		step(2);
		`CHK("kp_clear", 2'b00, {keypad_event_flag, keypad_irq});
		power_down = 1'b1;
		key = 24'h00_0008;
		step(5);
		`CHK("kp_wake", 1'b1, keypad_wake);
		power_down = 1'b0;
		key = 24'h00_0000;
		$display("done keypad");
		osc_select = 3'h0;
		port2_mode_reg_one = 8'h80;
		step(4);
		count_toggles(40);
		`CHK("xtal_noclk", 2'b00, {clkout_active, n > 0});
		osc_select = 3'h3;
		cpu_clock_divider = 8'h01;
		step(30);
		`CHK("clk_on", 1'b1, clkout_active);
		count_toggles(120);
		`CHK("clk_div1", 1'b1, n >= 9 && n <= 11);
		cpu_clock_divider = 8'h00;
		idle_mode = 1'b1;
		step(10);
		count_toggles(120);
		`CHK("clk_div0", 1'b1, n >= 39 && n <= 41);
		$display("done clkout");
		print_verdict();
	end
endmodule
`default_nettype wire
